// *** hdl/btec_defs.vh ***
`ifndef BTEC_DEFS_VH
`define BTEC_DEFS_VH
// Register byte offsets
`define BTEC_CTRL_OFS   8'h00
`define BTEC_SEV_OFS    8'h04
`define BTEC_STS_OFS    8'h08
`define BTEC_ERR_OFS    8'h0c
`define BTEC_HDR_OFS    8'h10
`define BTEC_STAT_OFS   8'h14
// Control register fields
`define BTEC_CTRL_MPS_LO 0
`define BTEC_CTRL_MPS_HI 2
`define BTEC_CTRL_DSP    3
`define BTEC_CTRL_D3HOT  4
`define BTEC_CTRL_ECRC_LO 8
`define BTEC_CTRL_RST   32'h0000_0000
// Severity bits, set means fatal
`define BTEC_SEV_UCPL   0
`define BTEC_SEV_ECRC   1
`define BTEC_SEV_UR     2
`define BTEC_SEV_RST    3'h0
// Status bits, write one to clear
`define BTEC_STS_PSTA   0
`define BTEC_STS_SSTA   1
// Error status bits, write one to clear
`define BTEC_ERR_UCPL   0
`define BTEC_ERR_OVF    1
`define BTEC_ERR_MALF   2
`define BTEC_ERR_MCB    3
`define BTEC_ERR_ECRC   4
`define BTEC_ERR_UR     5
// TLP type codes
`define BTEC_TY_MEM     5'h00
`define BTEC_TY_MEMLK   5'h01
`define BTEC_TY_IO      5'h02
`define BTEC_TY_CFG0    5'h04
`define BTEC_TY_CFG1    5'h05
`define BTEC_TY_CPL     5'h0a
`define BTEC_TY_CPLLK   5'h0b
// Vendor defined message codes
`define BTEC_MSG_VD0    8'h7e
`define BTEC_MSG_VD1    8'h7f
// Payload limit for an MPS code of zero, in dwords
`define BTEC_MPS_BASE   11'h020
// Ceiling for MPS codes whose shift would pass 1024 dwords
`define BTEC_MPS_TOP    3'h5
`define BTEC_MPS_CEIL   11'h400
// Recognised message codes besides the vendor ones
`define BTEC_MSG_UNLOCK   8'h00
`define BTEC_MSG_PM_NAK   8'h14
`define BTEC_MSG_PME      8'h18
`define BTEC_MSG_PME_OFF  8'h19
`define BTEC_MSG_PME_ACK  8'h1b
`define BTEC_MSG_INTA_ON  8'h20
`define BTEC_MSG_INTB_ON  8'h21
`define BTEC_MSG_INTC_ON  8'h22
`define BTEC_MSG_INTD_ON  8'h23
`define BTEC_MSG_INTA_OFF 8'h24
`define BTEC_MSG_INTB_OFF 8'h25
`define BTEC_MSG_INTC_OFF 8'h26
`define BTEC_MSG_INTD_OFF 8'h27
`define BTEC_MSG_ERR_COR  8'h30
`define BTEC_MSG_ERR_NF   8'h31
`define BTEC_MSG_ERR_FAT  8'h33
`define BTEC_MSG_PWR_LIM  8'h50
`endif

// *** hdl/btec_checker.v ***
`timescale 1ns/1ps
`default_nettype none
`include "btec_defs.vh"
module btec_checker #(
  parameter NF = 4,
  parameter FW = 2
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  input  wire        tlpValid,
  input  wire [2:0]  tlpFmt,
  input  wire [4:0]  tlpType,
  input  wire [2:0]  tlpTc,
  input  wire [1:0]  tlpAttr,
  input  wire        tlpTd,
  input  wire        tlpEp,
  input  wire [9:0]  tlpLength,
  input  wire [3:0]  tlpLastBe,
  input  wire [7:0]  tlpMsgCode,
  input  wire [10:0] tlpPayDw,
  input  wire [10:0] tlpTotDw,
  input  wire        tlpEcrcOk,
  input  wire        tlpFromLink,
  input  wire        tlpSecondary,
  input  wire        tlpToBridge,
  input  wire        tlpDownstream,
  input  wire        tlpClaimed,
  input  wire [FW-1:0] tlpFunc,
  input  wire        tlpUnexpCpl,
  input  wire        tlpMcBlocked,
  input  wire        rxOverflow,
  input  wire        linkUpPin,
  output reg         dropTlp,
  output reg         nullifyTlp,
  output reg         urCplReq,
  output reg         urCplFunc0,
  output reg         corrErr,
  output reg         uncorrErr,
  output reg         hdrLogEn,
  output reg         portEcrcEn
);

  // Software state
  reg [31:0] ctrl_r;
  reg [2:0]  sev_r;
  reg [1:0]  sts_r;
  reg [5:0]  err_r;
  reg [24:0] hdr_r;
  reg [1:0]  sts_nxt;
  reg [5:0]  err_nxt;

  // Link state synchroniser, three stages; the pin comes from another
  // domain, and the compare of stages two and three rejects a one-cycle
  // glitch that would otherwise flip the link-down UR decision
  reg lnkS1_r;
  reg lnkS2_r;
  reg lnkS3_r;
  reg linkUp_r;

  // Field decode of the presented header; all judgement is made in the
  // cycle the descriptor is offered, so nothing is held per TLP
  wire withData = tlpFmt[1];
  wire hdr4Dw   = tlpFmt[0];
  wire isMsg    = (tlpType[4:3] == 2'b10);
  wire isMem    = (tlpType == `BTEC_TY_MEM);
  wire isMemLk  = (tlpType == `BTEC_TY_MEMLK);
  wire isIo     = (tlpType == `BTEC_TY_IO);
  wire isCfg    = (tlpType == `BTEC_TY_CFG0) ||
                  (tlpType == `BTEC_TY_CFG1);
  wire isCpl    = (tlpType == `BTEC_TY_CPL) ||
                  (tlpType == `BTEC_TY_CPLLK);
  wire isVd0    = isMsg && (tlpMsgCode == `BTEC_MSG_VD0);
  wire isVd1    = isMsg && (tlpMsgCode == `BTEC_MSG_VD1);
  wire isReq    = !isCpl;
  wire isNonPosted = !isCpl && !isMsg && !(isMem && withData);

  // Length 0 encodes 1024 dwords; the eleventh bit keeps that case apart
  // from a true zero in every size compare below
  wire [10:0] lenDw = (tlpLength == 10'h000) ? 11'h400
                                            : {1'b0, tlpLength};

  // Legal format and type pairs of the base protocol
  reg fmtTypeOk;
  always @* begin
    fmtTypeOk = 1'b0;
    if (!tlpFmt[2]) begin
      if (isMem)
        fmtTypeOk = 1'b1;
      else if (isMemLk || isIo || isCfg)
        fmtTypeOk = !hdr4Dw;
      else if (isCpl)
        fmtTypeOk = !hdr4Dw;
      else if (isMsg)
        fmtTypeOk = hdr4Dw;
    end
  end

  // Message codes this port recognises; anything else aimed at the
  // bridge is an unsupported request, so a new code needs a line here
  reg msgCodeOk;
  always @* begin
    case (tlpMsgCode)
      `BTEC_MSG_UNLOCK,
      `BTEC_MSG_PM_NAK,
      `BTEC_MSG_PME,
      `BTEC_MSG_PME_OFF,
      `BTEC_MSG_PME_ACK,
      `BTEC_MSG_INTA_ON,
      `BTEC_MSG_INTB_ON,
      `BTEC_MSG_INTC_ON,
      `BTEC_MSG_INTD_ON,
      `BTEC_MSG_INTA_OFF,
      `BTEC_MSG_INTB_OFF,
      `BTEC_MSG_INTC_OFF,
      `BTEC_MSG_INTD_OFF,
      `BTEC_MSG_ERR_COR,
      `BTEC_MSG_ERR_NF,
      `BTEC_MSG_ERR_FAT,
      `BTEC_MSG_PWR_LIM,
      `BTEC_MSG_VD0,
      `BTEC_MSG_VD1: begin
        msgCodeOk = 1'b1;
      end
      default: begin
        msgCodeOk = 1'b0;
      end
    endcase
  end

  // Payload limit in dwords from the programmed MPS code; codes above
  // five would shift out of range, and no TLP carries more than 1024
  // dwords, so they are held at that ceiling
  wire [2:0] mpsCode =
    ctrl_r[`BTEC_CTRL_MPS_HI:`BTEC_CTRL_MPS_LO];
  wire [10:0] mpsDw = (mpsCode > `BTEC_MPS_TOP) ?
                      `BTEC_MPS_CEIL : (`BTEC_MPS_BASE << mpsCode);

  // Expected total length, header plus payload plus digest
  wire [10:0] hdrDw  = hdr4Dw ? 11'h004 : 11'h003;
  wire [10:0] payExp = withData ? lenDw : 11'h000;
  wire [10:0] totExp = hdrDw + payExp + 11'h001;

  wire badFmt  = !fmtTypeOk;
  wire badMps  = withData && (lenDw > mpsDw);
  wire badLen  = withData && (lenDw != tlpPayDw);
  wire badTot  = tlpTd && (tlpTotDw != totExp);
  wire badShape = (isIo || isCfg) && fmtTypeOk &&
                  ((lenDw != 11'h001) || (tlpTc != 3'h0) ||
                   (tlpAttr != 2'h0) || (tlpLastBe != 4'h0));
  wire malformed = tlpFromLink &&
                   (badFmt || badMps || badLen || badTot || badShape);

  wire [NF-1:0] funcEcrc = ctrl_r[`BTEC_CTRL_ECRC_LO +: NF];
  wire portEcrc = |funcEcrc;
  wire ecrcFail = portEcrc && tlpTd && !tlpEcrcOk;
  // An index beyond NF names no function and so never reports
  wire funcInRange = (tlpFunc < NF);
  wire ecrcRep = ecrcFail && funcInRange && funcEcrc[tlpFunc];

  // Unsupported request conditions, aimed at the bridge except the link-down one
  // vendor type 0 message
  wire urVd0  = tlpToBridge && isVd0;
  wire urCode = tlpToBridge && isMsg && !msgCodeOk;
  wire urPois = tlpToBridge && tlpEp &&
                ((isIo) || (isMem && withData) ||
                 (isMsg && withData && !isVd0 && !isVd1));
  wire urD3   = tlpToBridge && isReq &&
                ctrl_r[`BTEC_CTRL_D3HOT];
  wire urLink = ctrl_r[`BTEC_CTRL_DSP] && !linkUp_r &&
                tlpDownstream;
  wire unsupp = urVd0 || urCode || urPois || urD3 || urLink;
  wire vd1Drop = tlpToBridge && isVd1 && !unsupp;

  wire ucplFatal = sev_r[`BTEC_SEV_UCPL];
  // Advisory ECRC only as intermediate link receiver
  wire ecrcAdv = !sev_r[`BTEC_SEV_ECRC] && tlpFromLink &&
                 !tlpToBridge;
  // Advisory UR only for non-posted requests
  wire urAdv = !sev_r[`BTEC_SEV_UR] && isNonPosted;

  // Error class for this TLP; overflow and malformed dominate. Only the
  // highest class acts, so one packet never raises both error pulses and
  // a header that failed formation is not judged again for routing
  wire evOvf  = rxOverflow;
  wire evMalf = tlpValid && malformed && !evOvf;
  wire evMcb  = tlpValid && tlpMcBlocked && !evOvf && !malformed;
  wire upper  = evOvf || malformed || tlpMcBlocked;
  wire evEcrc = tlpValid && ecrcRep && !upper;
  wire evUcpl = tlpValid && tlpUnexpCpl && !upper && !ecrcRep;
  wire evUr   = tlpValid && unsupp && !upper && !ecrcRep &&
                !tlpUnexpCpl;
  wire evVd1  = tlpValid && vd1Drop && !upper && !ecrcRep &&
                !tlpUnexpCpl;

  // Write decode, one strobe per writable register
  wire wrCtrl = regWr && (regAddr == `BTEC_CTRL_OFS);
  wire wrSev  = regWr && (regAddr == `BTEC_SEV_OFS);
  wire wrSts  = regWr && (regAddr == `BTEC_STS_OFS);
  wire wrErr  = regWr && (regAddr == `BTEC_ERR_OFS);

  // Sticky status; hardware set wins over software clear, so an error
  // that lands in the cycle of its clear is never lost
  always @* begin
    sts_nxt = sts_r;
    err_nxt = err_r;
    if (wrSts)
      sts_nxt = sts_r & ~regWdata[1:0];
    if (wrErr)
      err_nxt = err_r & ~regWdata[5:0];
    if (evMcb && !tlpSecondary)
      sts_nxt[`BTEC_STS_PSTA] = 1'b1;
    if (evMcb && tlpSecondary)
      sts_nxt[`BTEC_STS_SSTA] = 1'b1;
    if (evUcpl)
      err_nxt[`BTEC_ERR_UCPL] = 1'b1;
    if (evOvf)
      err_nxt[`BTEC_ERR_OVF] = 1'b1;
    if (evMalf)
      err_nxt[`BTEC_ERR_MALF] = 1'b1;
    if (evMcb)
      err_nxt[`BTEC_ERR_MCB] = 1'b1;
    if (evEcrc)
      err_nxt[`BTEC_ERR_ECRC] = 1'b1;
    if (evUr)
      err_nxt[`BTEC_ERR_UR] = 1'b1;
  end

  // Control, severity and sticky registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `BTEC_CTRL_RST;
      sev_r  <= `BTEC_SEV_RST;
      sts_r  <= 2'h0;
      err_r  <= 6'h00;
    end else begin
      if (wrCtrl)
        ctrl_r <= regWdata;
      if (wrSev)
        sev_r <= regWdata[2:0];
      sts_r <= sts_nxt;
      err_r <= err_nxt;
    end
  end

  // Header log keeps the last logged TLP; overflow never logs, since the
  // header of an overflowed packet was never fully received
  wire logHdr = evMalf || evMcb || evEcrc || evUcpl || evUr;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hdr_r <= 25'h0;
    end else if (logHdr) begin
      hdr_r <= {tlpFmt, tlpType, tlpTc, tlpAttr,
                tlpTd, tlpEp, tlpLength};
    end
  end

  // Link state: a change counts once stages two and three agree
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lnkS1_r  <= 1'b0;
      lnkS2_r  <= 1'b0;
      lnkS3_r  <= 1'b0;
      linkUp_r <= 1'b0;
    end else begin
      lnkS1_r <= linkUpPin;
      lnkS2_r <= lnkS1_r;
      lnkS3_r <= lnkS2_r;
      if (lnkS2_r == lnkS3_r)
        linkUp_r <= lnkS3_r;
    end
  end

  // Action outputs, one cycle after the TLP is presented. Registering
  // them costs a cycle of latency but keeps the pins free of decode
  // glitches from the wide header compare
  // no flow control error source exists
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dropTlp    <= 1'b0;
      nullifyTlp <= 1'b0;
      urCplReq   <= 1'b0;
      urCplFunc0 <= 1'b0;
      corrErr    <= 1'b0;
      uncorrErr  <= 1'b0;
      hdrLogEn   <= 1'b0;
      portEcrcEn <= 1'b0;
    end else begin
      nullifyTlp <= evOvf || evMalf || evMcb;
      dropTlp <= evUcpl || evUr || evVd1 ||
                 (evEcrc && tlpToBridge);
      urCplReq   <= evUr && isNonPosted;
      urCplFunc0 <= evUr && isNonPosted && !tlpClaimed;
      corrErr <= (evUcpl && !ucplFatal) ||
                 (evEcrc && ecrcAdv) || (evUr && urAdv);
      uncorrErr <= evOvf || evMalf || evMcb ||
                   (evUcpl && ucplFatal) ||
                   (evEcrc && !ecrcAdv) || (evUr && !urAdv);
      hdrLogEn <= logHdr;
      portEcrcEn <= portEcrc;
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero. Reads have
  // no side effect, so status is only ever cleared by a write of ones
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `BTEC_CTRL_OFS: regRdata <= ctrl_r;
        `BTEC_SEV_OFS:  regRdata <= {29'h0, sev_r};
        `BTEC_STS_OFS:  regRdata <= {30'h0, sts_r};
        `BTEC_ERR_OFS:  regRdata <= {26'h0, err_r};
        `BTEC_HDR_OFS:  regRdata <= {7'h0, hdr_r};
        `BTEC_STAT_OFS: regRdata <= {30'h0, portEcrc, linkUp_r};
        default:        regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

endmodule // btec_checker
`default_nettype wire

// *** sim/btec_checker_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "btec_defs.vh"
// Port-level watch on the error checker reactions
module btec_checker_properties #(
  parameter NF = 4
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        tlpValid,
  input wire logic [2:0]  tlpFmt,
  input wire logic [4:0]  tlpType,
  input wire logic [9:0]  tlpLength,
  input wire logic        tlpTd,
  input wire logic        tlpFromLink,
  input wire logic        tlpUnexpCpl,
  input wire logic        tlpMcBlocked,
  input wire logic        rxOverflow,
  input wire logic        dropTlp,
  input wire logic        nullifyTlp,
  input wire logic        urCplReq,
  input wire logic        urCplFunc0,
  input wire logic        corrErr,
  input wire logic        uncorrErr,
  input wire logic        hdrLogEn,
  input wire logic        portEcrcEn
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  // Overflow never logs a header
  property p_ovf; rxOverflow |=> nullifyTlp && uncorrErr && !hdrLogEn;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow");
  property p_malf; tlpValid && tlpFromLink && !rxOverflow && tlpFmt[2]
    |=> nullifyTlp && uncorrErr && hdrLogEn; endproperty
  a_malf: assert property (p_malf) else $error("bad format");
  property p_io; tlpValid && tlpFromLink && !rxOverflow &&
    tlpType == `BTEC_TY_IO && tlpLength != 10'h1 |=> nullifyTlp; endproperty
  a_io: assert property (p_io) else $error("io length");
  property p_mcb; tlpValid && tlpMcBlocked && !tlpFromLink && !rxOverflow
    |=> nullifyTlp && uncorrErr && hdrLogEn; endproperty
  a_mcb: assert property (p_mcb) else $error("multicast");
  // Completion with no digest and no higher error
  property p_ucpl; tlpValid && tlpUnexpCpl && !tlpMcBlocked && !tlpTd &&
    !tlpFromLink && !rxOverflow |=> dropTlp && hdrLogEn; endproperty
  a_ucpl: assert property (p_ucpl) else $error("unexp cpl");
  // Enable follows the control write after two cycles of lag
  property p_ecrc; regWr && regAddr == 8'h00 && |regWdata[8+:NF]
    |-> ##2 portEcrcEn; endproperty
  a_ecrc: assert property (p_ecrc) else $error("port ecrc");
  property p_one; corrErr || uncorrErr |-> corrErr != uncorrErr &&
    ($past(tlpValid) || $past(rxOverflow)); endproperty
  a_one: assert property (p_one) else $error("error class");
  property p_ur0; urCplFunc0 |-> urCplReq && $past(tlpValid); endproperty
  a_ur0: assert property (p_ur0) else $error("ur completion");
endmodule // btec_checker_properties
bind btec_checker btec_checker_properties #(.NF(NF))
  btec_checker_properties_i (.*);
`default_nettype wire

// *** sim/btec_link_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Link side: hands over one TLP descriptor per call
module btec_link_partner (
  input  wire logic   core_clk,
  output logic        tlpValid,
  output logic        rxOverflow,
  output logic [68:0] desc
);
  // Quiet link at start
  initial begin
    tlpValid = 1'b0;
    rxOverflow = 1'b0;
    desc = '0;
  end
  // True totals unless a flag asks for a corrupt count
  task send(input logic [7:0] ft, input logic [9:0] n,
            input logic [10:0] p, input logic [7:0] m,
            input logic [15:0] fl);
    logic [10:0] tot;
    tot = (ft[5] ? 11'h4 : 11'h3) + (ft[6] ? p : 11'h0)
          + {10'h0, fl[2]} + {10'h0, fl[9]};
    @(posedge core_clk);
    tlpValid <= !fl[15];
    rxOverflow <= fl[15];
    desc <= {ft, fl[10] ? 3'h1 : 3'h0, 1'b0, fl[11], fl[2], fl[3], n,
             {3'h0, fl[12]}, m, p, tot, !fl[8], fl[0], fl[4], fl[1],
             fl[5], fl[14], 1'b0, fl[13], fl[6], fl[7]};
    @(posedge core_clk);
    tlpValid <= 1'b0;
    rxOverflow <= 1'b0;
    // Released fields flip so stale values cannot pass
    desc <= ~desc;
  endtask
endmodule // btec_link_partner
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Descriptor flags for the link model
  localparam logic [15:0] L = 16'h1, B = 16'h2, T = 16'h4, E = 16'h8;
  localparam logic [15:0] S = 16'h10, D = 16'h20, U = 16'h40, M = 16'h80;
  localparam logic [15:0] X = 16'h100, Z = 16'h200, C = 16'h400;
  localparam logic [15:0] A = 16'h800, W = 16'h1000, F = 16'h2000;
  localparam logic [15:0] K = 16'h4000;
  localparam logic [15:0] V = 16'h8000;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        linkUpPin = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic        tlpValid, rxOverflow, tlpTd, tlpEp, tlpEcrcOk, tlpFromLink;
  logic        tlpSecondary, tlpToBridge, tlpDownstream, tlpClaimed;
  logic        tlpUnexpCpl, tlpMcBlocked, dropTlp, nullifyTlp, urCplReq;
  logic        urCplFunc0, corrErr, uncorrErr, hdrLogEn, portEcrcEn;
  logic [2:0]  tlpFmt, tlpTc;
  logic [4:0]  tlpType;
  logic [1:0]  tlpAttr, tlpFunc;
  logic [9:0]  tlpLength;
  logic [3:0]  tlpLastBe;
  logic [7:0]  tlpMsgCode;
  logic [10:0] tlpPayDw, tlpTotDw;
  logic [68:0] desc;
  int          errTotal = 0;
  int          comparisons = 0;
  // Fan the descriptor out to the header ports
  assign {tlpFmt, tlpType, tlpTc, tlpAttr, tlpTd, tlpEp, tlpLength,
          tlpLastBe, tlpMsgCode, tlpPayDw, tlpTotDw, tlpEcrcOk, tlpFromLink,
          tlpSecondary, tlpToBridge, tlpDownstream, tlpClaimed, tlpFunc,
          tlpUnexpCpl, tlpMcBlocked} = desc;
  btec_checker btec_checker_i (.*);
  btec_link_partner btec_link_partner_i (.*);
  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 check(regRdata, e);
  endtask
  // Send, compare pulses, then error log; drop is free on UR cases
  task run(input logic [7:0] ft, input logic [9:0] n, input logic [10:0] p,
           input logic [7:0] m, input logic [15:0] fl,
           input logic [6:0] o, input logic [5:0] e);
    logic [6:0] g;
    btec_link_partner_i.send(ft, n, p, m, fl);
    #1 g = {dropTlp, nullifyTlp, urCplReq, urCplFunc0, corrErr, uncorrErr,
            hdrLogEn};
    check({25'h0, g & (e[5] ? 7'h3f : 7'h7f)}, {25'h0, o});
    rd(8'h0c, {26'h0, e});
    wr(8'h0c, 32'h3f);
  endtask
  task printVerdict;
    $display("mismatches %0d comparisons %0d", errTotal, comparisons);
    if (errTotal == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this is over fifteen times that
  initial begin
    #20000;
    errTotal++;
    printVerdict;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    run(8'h40, 10'h4, 11'h4, 8'h0, L, 7'h00, 6'h00);
    run(8'h80, 10'h1, 11'h0, 8'h0, L, 7'h23, 6'h04);
    run(8'h40, 10'h4, 11'h3, 8'h0, L, 7'h23, 6'h04);
    run(8'h40, 10'h40, 11'h40, 8'h0, L, 7'h23, 6'h04);
    wr(8'h00, 32'h1);
    run(8'h40, 10'h40, 11'h40, 8'h0, L, 7'h00, 6'h00);
    run(8'h00, 10'h1, 11'h0, 8'h0, L | T | Z, 7'h23, 6'h04);
    run(8'h02, 10'h1, 11'h0, 8'h0, L | C, 7'h23, 6'h04);
    run(8'h44, 10'h1, 11'h1, 8'h0, L | A, 7'h23, 6'h04);
    run(8'h04, 10'h1, 11'h0, 8'h0, L | W, 7'h23, 6'h04);
    run(8'h02, 10'h2, 11'h0, 8'h0, 16'h0, 7'h00, 6'h00);
    run(8'h02, 10'h2, 11'h0, 8'h0, L, 7'h23, 6'h04);
    rd(8'h10, 32'h0004_0002);
    run(8'h00, 10'h1, 11'h0, 8'h0, V, 7'h22, 6'h02);
    rd(8'h10, 32'h0004_0002);
    $display("test formation done");
    run(8'h40, 10'h1, 11'h1, 8'h0, M | S, 7'h23, 6'h08);
    rd(8'h08, 32'h2);
    wr(8'h08, 32'h3);
    run(8'h40, 10'h1, 11'h1, 8'h0, M, 7'h23, 6'h08);
    rd(8'h08, 32'h1);
    wr(8'h08, 32'h3);
    run(8'h4a, 10'h1, 11'h1, 8'h0, U, 7'h45, 6'h01);
    wr(8'h04, 32'h1);
    run(8'h4a, 10'h1, 11'h1, 8'h0, U, 7'h43, 6'h01);
    wr(8'h04, 32'h0);
    $display("test events done");
    run(8'h34, 10'h0, 11'h0, 8'h7e, B, 7'h03, 6'h20);
    run(8'h34, 10'h0, 11'h0, 8'h7f, B, 7'h40, 6'h00);
    run(8'h34, 10'h0, 11'h0, 8'h01, B, 7'h03, 6'h20);
    run(8'h40, 10'h1, 11'h1, 8'h0, B | E, 7'h03, 6'h20);
    wr(8'h00, 32'h10);
    run(8'h00, 10'h1, 11'h0, 8'h0, B, 7'h1d, 6'h20);
    run(8'h00, 10'h1, 11'h0, 8'h0, B | K, 7'h15, 6'h20);
    wr(8'h00, 32'h8);
    run(8'h40, 10'h1, 11'h1, 8'h0, D, 7'h03, 6'h20);
    linkUpPin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(8'h14, 32'h1);
    run(8'h40, 10'h1, 11'h1, 8'h0, D, 7'h00, 6'h00);
    $display("test unsupported done");
    wr(8'h00, 32'h200);
    rd(8'h14, 32'h3);
    check({31'h0, portEcrcEn}, 32'h1);
    run(8'h00, 10'h1, 11'h0, 8'h0, L | T | X | F, 7'h05, 6'h10);
    run(8'h00, 10'h1, 11'h0, 8'h0, L | T | X, 7'h00, 6'h00);
    wr(8'h00, 32'h0);
    run(8'h00, 10'h1, 11'h0, 8'h0, L | T | X | F, 7'h00, 6'h00);
    $display("test ecrc done");
    wr(8'h00, 32'h1f);
    run(8'h40, 10'h0, 11'h400, 8'h0, L, 7'h00, 6'h00);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h1);
    $display("test reset again done");
    printVerdict;
  end
endmodule // tb
`default_nettype wire
